/* File: rtl/ciad_core.sv */
// Functional notes
// - finish current instruction before interrupt entry
// - entry stacks pc, vectors, five cycles
// - irq_exit pops address, sets mask, resumes
// - four sources, three masked by global bit
// - soft_trap always raises software interrupt
// - trap entry stacks pc, clears mask
// - fixed priority wake, timer0, timer1, trap
// - indexed: offset plus pointer low bits
// - indirect: pointer alone addresses data
// - direct: 8-bit field addresses data
// - immediate: 8-bit constant from stream
// - inherent: no operand bytes fetched
// - absolute: 11-bit target in two bytes
// - relative: pc plus displacement, -31..+32
// - masked requests stay pending until enabled
// - reset clears mask; set by mask_set_i or at the end of irq_exit
// - push minus two, low first; pull plus two, high first
`include "ciad_map.svh"
module ciad_core
  import ciad_pkg::*;
#(
  parameter logic [10:0] VEC_WAKE   = 11'h7FA,
  parameter logic [10:0] VEC_TIMER0 = 11'h7F8,
  parameter logic [10:0] VEC_TIMER1 = 11'h7F6,
  parameter logic [10:0] VEC_TRAP   = 11'h7FC
) (
  // clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  // peripheral request pulses
  input  wire logic       wake_edge_irq_i,
  input  wire logic       timer0_irq_i,
  input  wire logic       timer1_irq_i,
  // sequencer strobes, each for one cycle
  input  wire logic       instr_done_i,
  input  wire logic       soft_trap_i,
  input  wire logic       irq_exit_i,
  input  wire logic       mask_set_i,
  input  wire logic       mask_clr_i,
  input  wire logic [10:0] pc_i,
  // data memory port for the stack
  input  wire logic [7:0] mem_rdata_i,
  output logic [7:0]      mem_addr_o,
  output logic [7:0]      mem_wdata_o,
  output logic            mem_we_o,
  output logic            mem_re_o,
  // program counter load
  output logic            pc_load_o,
  output logic [10:0]     pc_next_o,
  // status
  output logic            busy_o,
  output logic            mask_o,
  output logic [3:0]      pending_o,
  output logic [3:0]      sp_o,
  // operand address generation
  input  wire ciad_opnd_t opnd_i,
  output ciad_ea_t        ea_o
);
  typedef enum logic [2:0] {CIAD_IDLE, CIAD_ENTRY, CIAD_EXIT} ciad_state_t;

  ciad_state_t state;
  logic [3:0]  pend;
  logic [3:0]  sp;
  logic        gmask;
  logic [2:0]  cyc;
  logic [1:0]  src;
  logic [10:0] ret_pc;
  logic [7:0]  pop_lo;
  logic [2:0]  pop_hi;
  logic [3:0]  eligible;
  logic        take;

  // pick highest eligible source
  function automatic logic [1:0] ciad_pick(input logic [3:0] v);
    if (v[`CIAD_SRC_WAKE])        return `CIAD_SRC_WAKE;
    else if (v[`CIAD_SRC_TIMER0]) return `CIAD_SRC_TIMER0;
    else if (v[`CIAD_SRC_TIMER1]) return `CIAD_SRC_TIMER1;
    else                          return `CIAD_SRC_SWTRAP;
  endfunction : ciad_pick

  function automatic logic [10:0] ciad_vec(input logic [1:0] s);
    unique case (s)
      `CIAD_SRC_WAKE:   return VEC_WAKE;
      `CIAD_SRC_TIMER0: return VEC_TIMER0;
      `CIAD_SRC_TIMER1: return VEC_TIMER1;
      default:          return VEC_TRAP;
    endcase
  endfunction : ciad_vec

  // trap ignores the mask, others need it set
  assign eligible = {pend[3:1] & {3{gmask}}, pend[0]};
  // entry only at an instruction boundary
  assign take = (state == CIAD_IDLE) && instr_done_i && (|eligible);

  // pending latches; set beats clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pend <= 4'h0;
    end else if (ce_i) begin
      pend <= (pend & ~((take ? 4'b0001 : 4'b0000) << ciad_pick(eligible)))
            | {wake_edge_irq_i, timer0_irq_i, timer1_irq_i, soft_trap_i};
    end
  end

  // global mask
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gmask <= 1'b0;
    end else if (ce_i) begin
      if (state == CIAD_ENTRY && cyc == `CIAD_ENTRY_CYC - 3'd1) gmask <= 1'b0;
      else if (state == CIAD_EXIT && cyc == `CIAD_EXIT_CYC - 3'd1) gmask <= 1'b1;
      else if (mask_set_i) gmask <= 1'b1;
      else if (mask_clr_i) gmask <= 1'b0;
    end
  end

  // entry and exit sequencing
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state  <= CIAD_IDLE;
      cyc    <= 3'd0;
      src    <= 2'd0;
      ret_pc <= `CIAD_PC_RESET;
    end else if (ce_i) begin
      unique case (state)
        CIAD_IDLE: begin
          cyc <= 3'd0;
          if (take) begin
            state  <= CIAD_ENTRY;
            src    <= ciad_pick(eligible);
            ret_pc <= pc_i;
          end else if (irq_exit_i) begin
            state <= CIAD_EXIT;
          end
        end
        CIAD_ENTRY: begin
          cyc <= cyc + 3'd1;
          if (cyc == `CIAD_ENTRY_CYC - 3'd1) state <= CIAD_IDLE;
        end
        CIAD_EXIT: begin
          cyc <= cyc + 3'd1;
          if (cyc == `CIAD_EXIT_CYC - 3'd1) state <= CIAD_IDLE;
        end
        default: state <= CIAD_IDLE;
      endcase
    end
  end

  // stack pointer; pull undoes the push, high byte first then low
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sp     <= `CIAD_SP_RESET;
      pop_hi <= 3'h0;
      pop_lo <= 8'h00;
    end else if (ce_i) begin
      if (state == CIAD_ENTRY && cyc == 3'd1) sp <= sp - `CIAD_SP_STEP;
      if (state == CIAD_EXIT && cyc == 3'd1) sp <= sp + `CIAD_SP_STEP;
      if (state == CIAD_EXIT && cyc == 3'd2) pop_hi <= mem_rdata_i[2:0];
      if (state == CIAD_EXIT && cyc == 3'd3) pop_lo <= mem_rdata_i;
    end
  end

  // stack memory traffic: push low at sp, high at sp-1; pull high, then low
  always_comb begin
    mem_addr_o  = 8'h00;
    mem_wdata_o = 8'h00;
    mem_we_o    = 1'b0;
    mem_re_o    = 1'b0;
    if (state == CIAD_ENTRY && cyc == 3'd0) begin
      mem_addr_o  = `CIAD_STACK_BASE | {4'h0, sp};
      mem_wdata_o = ret_pc[7:0];
      mem_we_o    = 1'b1;
    end else if (state == CIAD_ENTRY && cyc == 3'd1) begin
      mem_addr_o  = `CIAD_STACK_BASE | {4'h0, 4'(sp - 4'h1)};
      mem_wdata_o = {5'h00, ret_pc[10:8]};
      mem_we_o    = 1'b1;
    end else if (state == CIAD_EXIT && cyc == 3'd2) begin
      mem_addr_o  = `CIAD_STACK_BASE | {4'h0, 4'(sp - 4'h1)};
      mem_re_o    = 1'b1;
    end else if (state == CIAD_EXIT && cyc == 3'd3) begin
      mem_addr_o  = `CIAD_STACK_BASE | {4'h0, sp};
      mem_re_o    = 1'b1;
    end
  end

  // pc load at the final cycle of entry or exit
  always_comb begin
    pc_load_o = 1'b0;
    pc_next_o = 11'h000;
    if (state == CIAD_ENTRY && cyc == `CIAD_ENTRY_CYC - 3'd1) begin
      pc_load_o = 1'b1;
      pc_next_o = ciad_vec(src);
    end else if (state == CIAD_EXIT && cyc == `CIAD_EXIT_CYC - 3'd1) begin
      pc_load_o = 1'b1;
      pc_next_o = {pop_hi, pop_lo}; // memory is released here, use held bytes
    end
  end

  assign busy_o    = (state != CIAD_IDLE);
  assign mask_o    = gmask;
  assign pending_o = pend;
  assign sp_o      = sp;

  // operand address generation
  ciad_addr_gen u_addr_gen (
    .req_i (opnd_i),
    .ea_o  (ea_o)
  );

  // assertions
  sequence s_entry_start;
    take && ce_i;
  endsequence
  sequence s_entry_body;
    (state == CIAD_ENTRY)[*5] ##1 (state == CIAD_IDLE);
  endsequence
  a_entry_five_cycles: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    s_entry_start |=> s_entry_body)
    else $error("entry not five cycles");
  a_take_at_boundary: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(busy_o) && state == CIAD_ENTRY |-> $past(instr_done_i))
    else $error("entry started mid instruction");
  a_mask_reset_clear: assert property (@(posedge clk_i)
    !rst_n_i |=> !gmask) else $error("mask not cleared by reset");
  a_masked_no_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && !gmask && ce_i |=> src == `CIAD_SRC_SWTRAP) else $error("masked source taken");
  a_prio_wake_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    take && ce_i && eligible[3] |=> src == `CIAD_SRC_WAKE) else $error("priority wrong");
  a_exit_sets_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state == CIAD_EXIT && cyc == 3'd4 && ce_i |=> gmask) else $error("exit left mask clear");
  a_push_sp_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state == CIAD_ENTRY && cyc == 3'd1 && ce_i |=> sp == 4'($past(sp) - 4'h2))
    else $error("push step wrong");
  a_trap_pending: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    soft_trap_i && ce_i |=> pend[0]) else $error("trap lost");
  a_entry_clears_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pc_load_o && state == CIAD_ENTRY && ce_i |=> !gmask) else $error("entry kept mask");
endmodule : ciad_core

/* File: rtl/ciad_map.svh */
`ifndef CIAD_MAP_SVH
`define CIAD_MAP_SVH
// source indices into the request vector
`define CIAD_SRC_SWTRAP  2'd0
`define CIAD_SRC_TIMER1  2'd1
`define CIAD_SRC_TIMER0  2'd2
`define CIAD_SRC_WAKE    2'd3
// entry and return length in instruction cycles
`define CIAD_ENTRY_CYC   3'd5
`define CIAD_EXIT_CYC    3'd5
// stack window and pointer step
`define CIAD_STACK_BASE  8'h30
`define CIAD_SP_STEP     4'h2
`define CIAD_SP_RESET    4'hF
// program counter after reset
`define CIAD_PC_RESET    11'h000
// data space select bit of the pointer
`define CIAD_XSPACE_BIT  11
// relative reach
`define CIAD_REL_MIN     -31
`define CIAD_REL_MAX     32
`endif

/* File: rtl/ciad_pkg.sv */
package ciad_pkg;
  // addressing modes seen by the address generator
  typedef enum logic [2:0] {
    CIAD_AM_INDEXED,
    CIAD_AM_INDIRECT,
    CIAD_AM_DIRECT,
    CIAD_AM_IMMEDIATE,
    CIAD_AM_INHERENT,
    CIAD_AM_ABSOLUTE,
    CIAD_AM_RELATIVE
  } ciad_mode_t;

  // operand request from the sequencer
  typedef struct packed {
    ciad_mode_t  mode;
    logic [7:0]  byte1;
    logic [7:0]  byte2;
    logic [11:0] xptr;
    logic [10:0] pc;
  } ciad_opnd_t;

  // resolved operand
  typedef struct packed {
    logic [11:0] addr;
    logic        prog_space;
    logic [7:0]  imm;
    logic        has_imm;
    logic [1:0]  extra_bytes;
  } ciad_ea_t;
endpackage : ciad_pkg

/* File: rtl/ciad_addr_gen.sv */
`include "ciad_map.svh"
module ciad_addr_gen
  import ciad_pkg::*;
(
  // operand request
  input  wire ciad_opnd_t req_i,
  // resolved operand
  output ciad_ea_t       ea_o
);
  logic signed [6:0] rel;

  // relative displacement kept in -31..+32 by clamping byte1[6:0] as a signed value, bit 7 ignored; both ends stay reachable
  always_comb begin
    rel = $signed(req_i.byte1[6:0]);
    if (rel > $signed(7'(`CIAD_REL_MAX))) begin
      rel = $signed(7'(`CIAD_REL_MAX));
    end else if (rel < $signed(7'(`CIAD_REL_MIN))) begin
      rel = $signed(7'(`CIAD_REL_MIN));
    end
  end

  // effective address per mode
  always_comb begin
    ea_o = '0;
    unique case (req_i.mode)
      CIAD_AM_INDEXED: begin
        ea_o.addr        = {1'b0, 11'(req_i.xptr[10:0] + {3'b000, req_i.byte1})};
        ea_o.prog_space  = req_i.xptr[`CIAD_XSPACE_BIT];
        ea_o.addr[11]    = req_i.xptr[`CIAD_XSPACE_BIT];
        ea_o.extra_bytes = 2'd1;
      end
      CIAD_AM_INDIRECT: begin
        ea_o.addr        = {1'b0, req_i.xptr[10:0]};
      end
      CIAD_AM_DIRECT: begin
        ea_o.addr        = {4'h0, req_i.byte1};
        ea_o.extra_bytes = 2'd1;
      end
      CIAD_AM_IMMEDIATE: begin
        ea_o.imm         = req_i.byte1;
        ea_o.has_imm     = 1'b1;
        ea_o.extra_bytes = 2'd1;
      end
      CIAD_AM_INHERENT: begin
        ea_o.extra_bytes = 2'd0;
      end
      CIAD_AM_ABSOLUTE: begin
        ea_o.addr        = {1'b1, req_i.byte1[2:0], req_i.byte2};
        ea_o.prog_space  = 1'b1;
        ea_o.extra_bytes = 2'd2;
      end
      CIAD_AM_RELATIVE: begin
        ea_o.addr        = {1'b1, 11'(req_i.pc + 11'($signed(rel)))};
        ea_o.prog_space  = 1'b1;
      end
    endcase
  end
endmodule : ciad_addr_gen

/* File: tb/ciad_stack_mem.sv */
module ciad_stack_mem (
  // clock
  input  wire logic       clk_i,
  // stack port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  output logic [7:0]      rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] last;
  // known value on the bus before the first read
  initial begin
    last = 8'h5A;
  end
  // stack bytes land as the core writes them, low byte first
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    if (re_i) begin
      last <= mem[addr_i];
    end
  end
  // read answers at once; an idle bus shows the inverse of the last byte
  assign rdata_o = re_i ? mem[addr_i] : ~last;
endmodule : ciad_stack_mem

/* File: tb/tb.sv */
module tb
  import ciad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [10:0] V_WAKE = 11'h123;
  localparam logic [10:0] V_T0   = 11'h234;
  localparam logic [10:0] V_T1   = 11'h345;
  localparam logic [10:0] V_TRAP = 11'h456;
  logic clk_i, rst_n_i, ce_i, wake_i, t0_i, t1_i, done_i, trap_i, exit_i, mset_i, mclr_i;
  logic [10:0] pc_i, pc_next_o, pc_got, p;
  logic [7:0]  rdata, addr, wdata;
  logic        we, re, pc_load_o, busy_o, mask_o;
  logic [3:0]  pending_o, sp_o;
  ciad_opnd_t  opnd_i, o;
  ciad_ea_t    ea_o;
  logic [10:0] vec [4] = '{V_WAKE, V_T0, V_T1, V_TRAP};
  int          fail_count, total_checks, nb;

  ciad_core #(.VEC_WAKE(V_WAKE), .VEC_TIMER0(V_T0), .VEC_TIMER1(V_T1), .VEC_TRAP(V_TRAP)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .wake_edge_irq_i(wake_i),
    .timer0_irq_i(t0_i), .timer1_irq_i(t1_i), .instr_done_i(done_i), .soft_trap_i(trap_i),
    .irq_exit_i(exit_i), .mask_set_i(mset_i), .mask_clr_i(mclr_i), .pc_i(pc_i),
    .mem_rdata_i(rdata), .mem_addr_o(addr), .mem_wdata_o(wdata), .mem_we_o(we),
    .mem_re_o(re), .pc_load_o(pc_load_o), .pc_next_o(pc_next_o), .busy_o(busy_o),
    .mask_o(mask_o), .pending_o(pending_o), .sp_o(sp_o), .opnd_i(opnd_i), .ea_o(ea_o));

  ciad_stack_mem u_mem (.clk_i(clk_i), .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
    .rdata_o(rdata));

  // clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // capture the loaded program counter
  always @(posedge clk_i) begin
    if (pc_load_o === 1'b1) begin
      pc_got <= pc_next_o;
    end
  end

  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // one-cycle strobes {wake,t0,t1,done,trap,exit,mset,mclr}, then count busy cycles
  task automatic pulse(input logic [7:0] s);
    @(posedge clk_i);
    {wake_i, t0_i, t1_i, done_i, trap_i, exit_i, mset_i, mclr_i} <= s;
    @(posedge clk_i);
    {wake_i, t0_i, t1_i, done_i, trap_i, exit_i, mset_i, mclr_i} <= 8'h00;
    nb = 0;
    repeat (8) begin
      #1;
      if (busy_o === 1'b1) nb++;
      @(posedge clk_i);
    end
    #1;
  endtask : pulse

  // expected relative target with clamped displacement
  function automatic logic [10:0] rel_exp(input logic [10:0] pc, input logic [7:0] b);
    int d;
    d = b[6] ? int'(b[6:0]) - 128 : int'(b[6:0]);
    if (d < -31) d = -31;
    if (d > 32) d = 32;
    return pc + 11'(d);
  endfunction : rel_exp

  // watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    give_verdict();
  end

  // main sequence
  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    {wake_i, t0_i, t1_i, done_i, trap_i, exit_i, mset_i, mclr_i} = 8'h00;
    pc_i = 11'h000;
    opnd_i = '0;
    void'($urandom(32'h585e));
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk(mask_o, 0);
    chk(sp_o, 4'hF);
    pulse(8'h20);
    pulse(8'h10);
    chk(nb, 0);
    chk(pending_o, 4'h2);
    pulse(8'h02);
    chk(nb, 0);
    chk(mask_o, 1);
    p = 11'($urandom);
    @(posedge clk_i);
    pc_i <= p;
    pulse(8'h10);
    chk(nb, 5);
    chk(pc_got, V_T1);
    chk(u_mem.mem[8'h3F], p[7:0]);
    chk(u_mem.mem[8'h3E][2:0], p[10:8]);
    chk(sp_o, 4'hD);
    chk(mask_o, 0);
    pulse(8'h04);
    chk(nb, 5);
    chk(pc_got, p);
    chk(mask_o, 1);
    chk(sp_o, 4'hF);
    pulse(8'hE8);
    chk(pending_o, 4'hF);
    for (int k = 0; k < 4; k++) begin
      pulse(8'h10);
      chk(pc_got, vec[k]);
      chk(pending_o, 4'hF >> (k + 1));
      pulse(8'h02);
    end
    pulse(8'h01);
    pulse(8'h08);
    pulse(8'h10);
    chk(nb, 5);
    chk(pc_got, V_TRAP);
    chk(mask_o, 0);
    // trap taken with the mask clear: handler ends as a plain subroutine, mask stays clear
    pulse(8'h00);
    chk(mask_o, 0);
    // trap taken with the mask set: handler ends through irq_exit with a fresh return pc
    p = 11'($urandom);
    @(posedge clk_i);
    pc_i <= p;
    pulse(8'h02);
    pulse(8'h08);
    pulse(8'h10);
    chk(pc_got, V_TRAP);
    pulse(8'h04);
    chk(pc_got, p);
    chk(mask_o, 1);
    // operand address generation, random with relative corners
    for (int i = 0; i < 42; i++) begin
      o.mode = ciad_mode_t'(i % 7);
      o.byte1 = (i == 6) ? 8'h40 : (i == 13) ? 8'h3F : (i == 20) ? 8'h20 :
                (i == 27) ? 8'h61 : 8'($urandom);
      o.byte2 = 8'($urandom);
      o.xptr = 12'($urandom);
      o.pc = 11'($urandom);
      @(posedge clk_i);
      opnd_i <= o;
      #1;
      case (o.mode)
        CIAD_AM_INDEXED: begin
          chk(ea_o.addr[10:0], 11'(o.xptr[10:0] + 11'(o.byte1)));
          chk(ea_o.prog_space, o.xptr[11]);
        end
        CIAD_AM_INDIRECT: chk({ea_o.prog_space, ea_o.addr[10:0]}, {1'b0, o.xptr[10:0]});
        CIAD_AM_DIRECT: chk({ea_o.prog_space, ea_o.addr[10:0]}, {4'h0, o.byte1});
        CIAD_AM_IMMEDIATE: chk({ea_o.has_imm, ea_o.imm}, {1'b1, o.byte1});
        CIAD_AM_INHERENT: chk({ea_o.has_imm, ea_o.extra_bytes}, 0);
        CIAD_AM_ABSOLUTE: begin
          chk({ea_o.prog_space, ea_o.extra_bytes}, 3'b110);
          chk(ea_o.addr[10:0] == {o.byte1[2:0], o.byte2}
              || ea_o.addr[10:0] == {o.byte2[2:0], o.byte1}, 1);
        end
        default: chk(ea_o.addr[10:0], rel_exp(o.pc, o.byte1));
      endcase
    end
    give_verdict();
  end
endmodule : tb
